// ==== rtl/acr_defines.svh ====
// Register offsets, field positions, reset values for the calibration register bank
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------
`define ACR_ADDR_CH4_GAIN_CAL_HIGH 6'h20
`define ACR_ADDR_CH4_GAIN_CAL_LOW  6'h21
`define ACR_ADDR_CH5_CHANNEL_CFG   6'h22
`define ACR_ADDR_CH5_OFS_CAL_HIGH  6'h23
`define ACR_ADDR_CH5_OFS_CAL_LOW   6'h24
`define ACR_ADDR_CH5_GAIN_CAL_HIGH 6'h25

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACR_RST_GAIN_HIGH 16'h8000
`define ACR_RST_ZERO      16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACR_LOW_FIELD_MSB 15
`define ACR_LOW_FIELD_LSB 8
`define ACR_PHASE_MSB     15
`define ACR_PHASE_LSB     6
`define ACR_DCOFF_BIT     2
`define ACR_MUX_MSB       1
`define ACR_MUX_LSB       0

// Writable bit masks (reserved bits never stored)
`define ACR_MASK_FULL 16'hFFFF
`define ACR_MASK_LOW  16'hFF00
`define ACR_MASK_CFG  16'hFFC7

`endif

// ==== rtl/acr_pkg.sv ====
// Types shared by the calibration register bank
package acr_pkg;

   // Channel input selection codes
   typedef enum logic [1:0] {
      ACR_IN_PINS     = 2'b00,
      ACR_IN_SHORTED  = 2'b01,
      ACR_IN_TEST_POS = 2'b10,
      ACR_IN_TEST_NEG = 2'b11
   } acr_in_sel_t;

endpackage : acr_pkg

// ==== rtl/acr_input_decode.sv ====
// Channel input selection decoder
`timescale 1ns/1ps
module acr_input_decode (
   input  wire logic [1:0] inputSelect,
   output logic            selPins,
   output logic            selShorted,
   output logic            selTestPos,
   output logic            selTestNeg
);

   // ----------------------------------------------------------------
   // One-hot decode of the two-bit selection
   // ----------------------------------------------------------------
   always_comb begin
      selPins    = 1'b0;
      selShorted = 1'b0;
      selTestPos = 1'b0;
      selTestNeg = 1'b0;
      case (acr_pkg::acr_in_sel_t'(inputSelect))
         acr_pkg::ACR_IN_PINS:     selPins    = 1'b1;
         acr_pkg::ACR_IN_SHORTED:  selShorted = 1'b1;
         acr_pkg::ACR_IN_TEST_POS: selTestPos = 1'b1;
         acr_pkg::ACR_IN_TEST_NEG: selTestNeg = 1'b1;
         default:                  selPins    = 1'b1;
      endcase
   end

endmodule : acr_input_decode

// ==== rtl/acr_cal_regs.sv ====
// Channel 4/5 calibration and configuration register bank
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_cal_regs (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [5:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic      [15:0] regRdData,
   input  wire logic [3:0]  global_dc_filter_setting,
   output logic      [23:0] gainCorrCh4,
   output logic      [23:0] gainCorrCh5Upper,
   output logic      [23:0] offsetCorrCh5,
   output logic      [9:0]  phase_delay_ch5,
   output logic             dcFilterEnCh5,
   output logic      [1:0]  input_select_ch5,
   output logic             selPinsCh5,
   output logic             selShortedCh5,
   output logic             selTestPosCh5,
   output logic             selTestNegCh5
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] gain_corr_upper_ch4_q;
   logic [7:0]  gain_corr_lower_ch4_q;
   logic [9:0]  phaseCh5_q;
   logic        dcFilterOffCh5_q;
   logic [1:0]  inSelCh5_q;
   logic [15:0] offset_corr_upper_ch5_q;
   logic [7:0]  offset_corr_lower_ch5_q;
   logic [15:0] gain_corr_upper_ch5_q;
   logic [15:0] rdData_d;
   logic        selPins;
   logic        selShorted;
   logic        selTestPos;
   logic        selTestNeg;

   // ----------------------------------------------------------------
   // Channel 4 gain registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gain_corr_upper_ch4_q <= `ACR_RST_GAIN_HIGH;
         gain_corr_lower_ch4_q <= 8'h00;
      end else if (regWrStb) begin
         if (regAddr == `ACR_ADDR_CH4_GAIN_CAL_HIGH) begin
            gain_corr_upper_ch4_q <= regWrData;
         end
         if (regAddr == `ACR_ADDR_CH4_GAIN_CAL_LOW) begin
            gain_corr_lower_ch4_q <= regWrData[`ACR_LOW_FIELD_MSB:`ACR_LOW_FIELD_LSB];
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel 5 configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phaseCh5_q       <= 10'h000;
         dcFilterOffCh5_q <= 1'b0;
         inSelCh5_q       <= 2'h0;
      end else if (regWrStb && regAddr == `ACR_ADDR_CH5_CHANNEL_CFG) begin
         // Bits 5:3 are not stored, so writes there vanish
         phaseCh5_q       <= regWrData[`ACR_PHASE_MSB:`ACR_PHASE_LSB];
         dcFilterOffCh5_q <= regWrData[`ACR_DCOFF_BIT];
         inSelCh5_q       <= regWrData[`ACR_MUX_MSB:`ACR_MUX_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Channel 5 offset and gain registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         offset_corr_upper_ch5_q <= `ACR_RST_ZERO;
         offset_corr_lower_ch5_q <= 8'h00;
         gain_corr_upper_ch5_q   <= `ACR_RST_GAIN_HIGH;
      end else if (regWrStb) begin
         if (regAddr == `ACR_ADDR_CH5_OFS_CAL_HIGH) begin
            offset_corr_upper_ch5_q <= regWrData;
         end
         if (regAddr == `ACR_ADDR_CH5_OFS_CAL_LOW) begin
            offset_corr_lower_ch5_q <=
               regWrData[`ACR_LOW_FIELD_MSB:`ACR_LOW_FIELD_LSB];
         end
         if (regAddr == `ACR_ADDR_CH5_GAIN_CAL_HIGH) begin
            gain_corr_upper_ch5_q <= regWrData;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer, reserved bits forced to zero
   // ----------------------------------------------------------------
   always_comb begin
      case (regAddr)
         `ACR_ADDR_CH4_GAIN_CAL_HIGH: rdData_d = gain_corr_upper_ch4_q;
         `ACR_ADDR_CH4_GAIN_CAL_LOW:  rdData_d = {gain_corr_lower_ch4_q, 8'h00};
         `ACR_ADDR_CH5_CHANNEL_CFG:
            rdData_d = {phaseCh5_q, 3'b000, dcFilterOffCh5_q, inSelCh5_q};
         `ACR_ADDR_CH5_OFS_CAL_HIGH:  rdData_d = offset_corr_upper_ch5_q;
         `ACR_ADDR_CH5_OFS_CAL_LOW:   rdData_d = {offset_corr_lower_ch5_q, 8'h00};
         `ACR_ADDR_CH5_GAIN_CAL_HIGH: rdData_d = gain_corr_upper_ch5_q;
         default:                     rdData_d = 16'h0000;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (regRdStb) begin
         regRdData <= rdData_d;
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Input selection decode for channel 5
   // ----------------------------------------------------------------
   acr_input_decode u_decode (
      .inputSelect (inSelCh5_q),
      .selPins     (selPins),
      .selShorted  (selShorted),
      .selTestPos  (selTestPos),
      .selTestNeg  (selTestNeg)
   );

   // ----------------------------------------------------------------
   // Registered outputs to the conversion datapath
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gainCorrCh4      <= 24'h800000;
         gainCorrCh5Upper <= 24'h800000;
         offsetCorrCh5    <= 24'h000000;
         phase_delay_ch5  <= 10'h000;
         dcFilterEnCh5    <= 1'b0;
         input_select_ch5 <= 2'h0;
         selPinsCh5       <= 1'b1;
         selShortedCh5    <= 1'b0;
         selTestPosCh5    <= 1'b0;
         selTestNegCh5    <= 1'b0;
      end else begin
         // Unsigned gain, 800000h is unity
         gainCorrCh4      <= {gain_corr_upper_ch4_q, gain_corr_lower_ch4_q};
         // Lower channel 5 gain lives outside this bank; zero here
         gainCorrCh5Upper <= {gain_corr_upper_ch5_q, 8'h00};
         offsetCorrCh5    <= {offset_corr_upper_ch5_q, offset_corr_lower_ch5_q};
         phase_delay_ch5  <= phaseCh5_q;
         // Local disable overrides the global per-channel enable
         dcFilterEnCh5    <= global_dc_filter_setting != 4'h0 && !dcFilterOffCh5_q;
         input_select_ch5 <= inSelCh5_q;
         selPinsCh5       <= selPins;
         selShortedCh5    <= selShorted;
         selTestPosCh5    <= selTestPos;
         selTestNegCh5    <= selTestNeg;
      end
   end

endmodule : acr_cal_regs

// ==== dv/acr_cal_regs_sva.sv ====
// Port checker for the calibration register bank
`timescale 1ns/1ps
module acr_cal_regs_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [5:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [15:0] regRdData,
   input wire logic [3:0]  global_dc_filter_setting,
   input wire logic [23:0] gainCorrCh4,
   input wire logic [23:0] gainCorrCh5Upper,
   input wire logic [23:0] offsetCorrCh5,
   input wire logic [9:0]  phase_delay_ch5,
   input wire logic        dcFilterEnCh5,
   input wire logic [1:0]  input_select_ch5,
   input wire logic        selPinsCh5,
   input wire logic        selShortedCh5,
   input wire logic        selTestPosCh5,
   input wire logic        selTestNegCh5
);
   // ------------------------------------------------------------
   // Write decodes and properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire wrA20 = regWrStb && regAddr == 6'h20;
   wire wrA22 = regWrStb && regAddr == 6'h22;
   wire wrA24 = regWrStb && regAddr == 6'h24;
   a_low_byte_zero: assert property (
      regRdStb && (regAddr == 6'h21 || regAddr == 6'h24) |=> regRdData[7:0] == 8'h00)
      else $error("low byte not zero");
   a_cfg_rsvd_zero: assert property (
      regRdStb && regAddr == 6'h22 |=> regRdData[5:3] == 3'h0)
      else $error("config reserved not zero");
   a_write_readback: assert property (
      wrA20 ##1 (regRdStb && regAddr == 6'h20) |=> regRdData == $past(regWrData, 2))
      else $error("readback wrong");
   a_sel_one_hot: assert property (
      {selTestNegCh5, selTestPosCh5, selShortedCh5, selPinsCh5} == 4'h1 << input_select_ch5)
      else $error("input decode wrong");
   a_cfg_fields: assert property (
      wrA22 |-> ##3 {phase_delay_ch5, input_select_ch5} ==
      {$past(regWrData[15:6], 3), $past(regWrData[1:0], 3)})
      else $error("cfg out");
   a_dc_local_off: assert property (
      wrA22 && regWrData[2] |-> ##3 !dcFilterEnCh5)
      else $error("filter not off");
   a_dc_global_off: assert property (
      global_dc_filter_setting == 4'h0 |=> !dcFilterEnCh5)
      else $error("filter on without global");
   a_gain_upper: assert property (
      wrA20 |-> ##3 gainCorrCh4[23:8] == $past(regWrData, 3))
      else $error("gain upper out wrong");
   a_ofs_lower: assert property (
      wrA24 |-> ##3 offsetCorrCh5[7:0] == $past(regWrData[15:8], 3))
      else $error("offset lower out wrong");
   c_cfg_off: cover property (wrA22 && regWrData[2]);
   c_test_neg: cover property (selTestNegCh5);
   c_rd_low: cover property (regRdStb && regAddr == 6'h21);
endmodule : acr_cal_regs_sva

// ==== dv/acr_cal_regs_tb_top.sv ====
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
module acr_cal_regs_tb_top;
   logic        clk_sys = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [5:0]  regAddr = 6'h00, ra;
   logic [15:0] regWrData = 16'h0000, regRdData;
   logic [3:0]  global_dc_filter_setting = 4'h0;
   logic [23:0] gainCorrCh4, gainCorrCh5Upper, offsetCorrCh5;
   logic [9:0]  phase_delay_ch5;
   logic [1:0]  input_select_ch5;
   logic        dcFilterEnCh5, selPinsCh5, selShortedCh5, selTestPosCh5, selTestNegCh5;
   logic [15:0] mdl [6'h20:6'h25];
   logic [31:0] seed = 32'h53A3FD5C;
   int          fails = 0, n_compared = 0;
   acr_cal_regs u_dut (
      .clk_sys                  (clk_sys),
      .rst                      (rst),
      .regAddr                  (regAddr),
      .regWrData                (regWrData),
      .regWrStb                 (regWrStb),
      .regRdStb                 (regRdStb),
      .regRdData                (regRdData),
      .global_dc_filter_setting (global_dc_filter_setting),
      .gainCorrCh4              (gainCorrCh4),
      .gainCorrCh5Upper         (gainCorrCh5Upper),
      .offsetCorrCh5            (offsetCorrCh5),
      .phase_delay_ch5          (phase_delay_ch5),
      .dcFilterEnCh5            (dcFilterEnCh5),
      .input_select_ch5         (input_select_ch5),
      .selPinsCh5               (selPinsCh5),
      .selShortedCh5            (selShortedCh5),
      .selTestPosCh5            (selTestPosCh5),
      .selTestNegCh5            (selTestNegCh5)
   );
   initial forever #12.5 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [15:0] wmask(input logic [5:0] a);
      case (a)
         6'h21, 6'h24: return 16'hFF00;
         6'h22: return 16'hFFC7;
         6'h20, 6'h23, 6'h25: return 16'hFFFF;
         default: return 16'h0000;
      endcase
   endfunction : wmask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      regWrStb  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
      if (a >= 6'h20 && a <= 6'h25) mdl[a] = d & wmask(a);
   endtask : wr
   task automatic rd(input logic [5:0] a);
      regRdStb <= 1'b1;
      regAddr  <= a;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      #1 chk(regRdData, (a >= 6'h20 && a <= 6'h25) ? mdl[a] : 16'h0000);
      @(posedge clk_sys);
   endtask : rd
   task automatic resets(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (mdl[i]) mdl[i] = (i == 6'h20 || i == 6'h25) ? 16'h8000 : 16'h0000;
      @(posedge clk_sys);
   endtask : resets
   task automatic chkOut();
      #1 chk(gainCorrCh4, {mdl[6'h20], mdl[6'h21][15:8]});
      chk(gainCorrCh5Upper, {mdl[6'h25], 8'h00});
      chk(offsetCorrCh5, {mdl[6'h23], mdl[6'h24][15:8]});
      chk({phase_delay_ch5, input_select_ch5}, {mdl[6'h22][15:6], mdl[6'h22][1:0]});
      chk(dcFilterEnCh5, global_dc_filter_setting != 4'h0 && !mdl[6'h22][2]);
      chk({selTestNegCh5, selTestPosCh5, selShortedCh5, selPinsCh5},
          24'h1 << mdl[6'h22][1:0]);
      @(posedge clk_sys);
   endtask : chkOut
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      resets(10);
      chkOut();
      for (int a = 6'h1F; a <= 6'h26; a++) rd(6'(a));
      $display("reset values test done");
      for (int a = 6'h1F; a <= 6'h26; a++) begin
         wr(6'(a), 16'hFFFF);
         rd(6'(a));
      end
      $display("reserved bits test done");
      for (int m = 0; m < 8; m++) begin
         seed = lfsr(seed);
         global_dc_filter_setting <= (m[1:0] == 2'b01) ? 4'h0 : (seed[19:16] | 4'h1);
         wr(6'h22, {seed[15:3], 3'(m)});
         rd(6'h22);
         repeat (3) @(posedge clk_sys);
         chkOut();
      end
      $display("config decode test done");
      repeat (40) begin
         seed = lfsr(seed);
         ra = 6'h1E + 6'(seed[3:0] % 4'hA);
         wr(ra, seed[31:16]);
         rd(ra);
      end
      repeat (3) @(posedge clk_sys);
      chkOut();
      $display("random access test done");
      global_dc_filter_setting <= 4'h0;
      resets(2);
      chkOut();
      for (int a = 6'h20; a <= 6'h25; a++) rd(6'(a));
      $display("second reset test done");
      close_out();
   end
endmodule : acr_cal_regs_tb_top
bind acr_cal_regs acr_cal_regs_sva u_sva (
   .clk_sys                  (clk_sys),
   .rst                      (rst),
   .regAddr                  (regAddr),
   .regWrData                (regWrData),
   .regWrStb                 (regWrStb),
   .regRdStb                 (regRdStb),
   .regRdData                (regRdData),
   .global_dc_filter_setting (global_dc_filter_setting),
   .gainCorrCh4              (gainCorrCh4),
   .gainCorrCh5Upper         (gainCorrCh5Upper),
   .offsetCorrCh5            (offsetCorrCh5),
   .phase_delay_ch5          (phase_delay_ch5),
   .dcFilterEnCh5            (dcFilterEnCh5),
   .input_select_ch5         (input_select_ch5),
   .selPinsCh5               (selPinsCh5),
   .selShortedCh5            (selShortedCh5),
   .selTestPosCh5            (selTestPosCh5),
   .selTestNegCh5            (selTestNegCh5)
);
